/* File: psa_pkg.sv */
// Package holding register offsets, bit positions and mode codes for the status and alarm logic.
package psa_pkg;
   // Register offsets as seen by the serial command interface.
   localparam logic [7:0] OFS_ALERT_A = 8'h02;
   localparam logic [7:0] OFS_FAULT_A = 8'h03;
   localparam logic [7:0] OFS_TEMP_DIAG_ALERT = 8'h04;
   localparam logic [7:0] OFS_TEMP_DIAG_FAULT = 8'h05;
   localparam logic [7:0] OFS_PACK_STATUS = 8'h12;
   localparam logic [7:0] OFS_ALARM_LATCH = 8'h62;
   localparam logic [7:0] OFS_ALARM_LIVE = 8'h64;
   localparam logic [7:0] OFS_ALARM_MASK = 8'h66;
   // Pack status bit positions.
   localparam int PS_NORMAL = 15;
   localparam int PS_ALERT_SUMMARY = 13;
   localparam int PS_FAULT_SUMMARY = 12;
   localparam int PS_SEC_HI = 11;
   localparam int PS_SEC_LO = 10;
   localparam int PS_AUTO_SWITCH = 8;
   localparam int PS_RESET_FLAG = 7;
   localparam int PS_EDIT_MODE = 5;
   localparam int PS_ALERT_LINE = 4;
   localparam int PS_CHARGE_DRV = 3;
   localparam int PS_DISCHARGE_DRV = 2;
   localparam int PS_DETECTOR = 1;
   // Alarm bit positions, shared by latch, live and mask registers.
   localparam int AL_FAULT_A = 15;
   localparam int AL_FAULT_B = 14;
   localparam int AL_ALERT_A = 13;
   localparam int AL_ALERT_B = 12;
   localparam int AL_CHARGE_OFF = 11;
   localparam int AL_DISCHARGE_OFF = 10;
   localparam int AL_LOW_VOLTAGE = 9;
   localparam int AL_CHECK_HI = 7;
   localparam int AL_CHECK_LO = 6;
   localparam int AL_INIT_DONE = 2;
   localparam int AL_DETECTOR = 1;
   localparam int AL_RESET = 0;
   // Implemented alarm bits; the rest read as zero, except in the mask register before its first write.
   localparam logic [15:0] ALARM_IMPL = 16'hfec7;
   // Temperature and diagnostic byte: bit 2 is reserved.
   localparam logic [7:0] TEMP_DIAG_IMPL = 8'hfb;
   localparam logic [7:0] TEMP_DIAG_ALERT_IMPL = 8'hfb;
   localparam logic [15:0] ALARM_MASK_RESET = 16'hffff;
   // Security state encoding.
   typedef enum logic [1:0] {
      PSA_SEC_UNINIT = 2'b00,
      PSA_SEC_OPEN = 2'b01,
      PSA_SEC_UNUSED = 2'b10,
      PSA_SEC_LOCKED = 2'b11
   } psa_sec_e;
endpackage

/* File: psa_status_alarm.sv */
// Status words, alarm latch with mask and open-drain alert line of the protector.
//
// Operation
// - Fault byte: temperature and diagnostic fault bits.
// - Alert byte: diag alert bits seven to three, one, zero.
// - Status bit 15 high in normal mode.
// - Bits 13/12 flag any alerts/faults present, mask ignored.
// - Bits 11:10 show security state code.
// - Locked state refuses configuration reads, writes.
// - Bit 8 auto switch: loaded, toggled.
// - Bit 7 set on reset, cleared on exit.
// - Bit 5 set after enter-edit processed.
// - Bit 4 high while alert line driven.
// - Bits 3/2 show charge/discharge driver enable.
// - Bit 1 shows debounced detector level.
// - Latch bits 15..12 from masked byte sources.
// - Writing one clears a latch bit.
// - Alert line low while any latch set.
// - Bits 11/10 set on driver disabled.
// - Bit 9 set on low voltage shutdown.
// - Bits 7/6 set per check in normal.
// - Bit 2 set on initial evaluation done.
// - Bit 1 set on detector level change.
// - Bit 0 set while reset flag asserted.
// - Live register shows unmasked raw conditions.
// - Mask bit gates latch and alert line.
// - Check and init live bits pulse briefly.
module psa_status_alarm #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] fault_a_byte,
   input wire logic [7:0] alert_a_byte,
   input wire logic [7:0] temp_fault_in,
   input wire logic [7:0] temp_alert_in,
   input wire logic normal_mode,
   input wire logic charge_driver,
   input wire logic discharge_driver,
   input wire logic detector_level,
   input wire logic low_voltage_shutdown,
   input wire logic check_tick,
   input wire logic init_done,
   input wire logic enter_edit_cmd,
   input wire logic exit_edit_cmd,
   input wire logic auto_switch_toggle_cmd,
   input wire logic auto_switch_stored,
   input wire logic seal_cmd,
   input wire logic unlock_cmd,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic cfg_access,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_refused,
   output logic cfg_allowed,
   output logic auto_switch_ctrl,
   output logic alert_n_out,
   output logic alert_n_oe
);

   // Refuses parameter values that the register map cannot serve.
   generate
      if (ADDR_W < 8 || DATA_W != 16)
      begin : g_bad_params
         $error("psa_status_alarm: ADDR_W must be >= 8 and DATA_W must be 16");
      end
   endgenerate

   // Timing seen from the register side, for whoever integrates this block.
   // A read strobe is taken at a rising edge and the word stands on the read
   // port from that same edge until the following read strobe.
   // A write strobe is taken at a rising edge and acts at that same edge.
   // Writes to the latch offset clear only the positions written as one.
   // A source that sets a latch bit in the cycle of its clear keeps it set,
   // so an event that lands during servicing is never lost.
   // The alert line follows the latch one cycle late, which makes the
   // line flag in the status word agree with what the pin really shows.
   // Status bits 13 and 12 summarise the incoming bytes and ignore the
   // alarm mask; only the latch and the alert line obey the mask.
   // Driver-off latch bits react to the fall of a driver enable, whereas
   // the live register shows the driver-off condition as a level.
   // The detector latch bit reacts to any change of the debounced level,
   // in either direction.
   // The initial-evaluation bit is a one-shot that is re-armed when the
   // edit window is left, so a settings reload reports itself again.
   // The reset flag stays up from a full reset until the edit window is
   // left, and it keeps the reset latch bit set while it is up.
   // The security state reads as not initialised for one cycle only.
   // Locked state refuses configuration access and edit entry, but all
   // status registers stay readable and the latch stays clearable.
   // The alert output is open drain: its level is always low and only the
   // enable decides whether the line is pulled.

   logic [15:0] alarm_latch_r;
   logic [15:0] alarm_mask_r;
   logic [15:0] alarm_live;
   logic [15:0] alarm_set;
   logic [15:0] alarm_clr;
   logic [15:0] pack_status;
   logic [7:0] temp_fault;
   logic [7:0] temp_alert;
   logic [1:0] sec_r;
   logic auto_switch_r;
   logic reset_flag_r;
   logic edit_mode_r;
   logic detector_prev_r;
   logic charge_prev_r;
   logic discharge_prev_r;
   logic init_seen_r;
   logic [DATA_W-1:0] rdata_r;
   logic refused_r;
   logic alert_drv_r;
   logic alert_lvl_r;
   logic locked;
   logic detector_change;

   // Reserved bit of the temperature bytes is forced to zero.
   assign temp_fault = temp_fault_in & psa_pkg::TEMP_DIAG_IMPL;
   assign temp_alert = temp_alert_in & psa_pkg::TEMP_DIAG_ALERT_IMPL;
   assign locked = (sec_r == psa_pkg::PSA_SEC_LOCKED);
   assign detector_change = detector_level ^ detector_prev_r;

   // Reduces a byte to a present flag.
   function automatic logic any_set(input logic [7:0] b);
      any_set = |b;
   endfunction

   // Decodes a register address against one offset.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   // Live alarm conditions before the mask.
   always_comb
   begin
      alarm_live = 16'h0000;
      alarm_live[psa_pkg::AL_FAULT_A] = any_set(fault_a_byte);
      alarm_live[psa_pkg::AL_FAULT_B] = any_set(temp_fault);
      alarm_live[psa_pkg::AL_ALERT_A] = any_set(alert_a_byte);
      alarm_live[psa_pkg::AL_ALERT_B] = any_set(temp_alert);
      alarm_live[psa_pkg::AL_CHARGE_OFF] = ~charge_driver;
      alarm_live[psa_pkg::AL_DISCHARGE_OFF] = ~discharge_driver;
      alarm_live[psa_pkg::AL_LOW_VOLTAGE] = low_voltage_shutdown;
      alarm_live[psa_pkg::AL_CHECK_HI] = check_tick & normal_mode;
      alarm_live[psa_pkg::AL_CHECK_LO] = check_tick & normal_mode;
      alarm_live[psa_pkg::AL_INIT_DONE] = init_done & ~init_seen_r;
      alarm_live[psa_pkg::AL_DETECTOR] = detector_level;
      alarm_live[psa_pkg::AL_RESET] = reset_flag_r;
   end

   // Latch set terms; driver-off bits latch on the falling edge of the enable.
   always_comb
   begin
      alarm_set = alarm_live & alarm_mask_r & psa_pkg::ALARM_IMPL;
      alarm_set[psa_pkg::AL_CHARGE_OFF] = charge_prev_r & ~charge_driver
         & alarm_mask_r[psa_pkg::AL_CHARGE_OFF];
      alarm_set[psa_pkg::AL_DISCHARGE_OFF] = discharge_prev_r & ~discharge_driver
         & alarm_mask_r[psa_pkg::AL_DISCHARGE_OFF];
      alarm_set[psa_pkg::AL_DETECTOR] = detector_change
         & alarm_mask_r[psa_pkg::AL_DETECTOR];
      alarm_set[psa_pkg::AL_CHECK_HI] = alarm_set[psa_pkg::AL_CHECK_HI];
      alarm_set[psa_pkg::AL_INIT_DONE] = alarm_set[psa_pkg::AL_INIT_DONE];
   end

   // Only ones written to the latch offset clear bits.
   assign alarm_clr = (reg_wr && hit(reg_addr, psa_pkg::OFS_ALARM_LATCH)) ?
      reg_wdata : 16'h0000;

   // Alarm latch: set wins over a clear in the same cycle.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         alarm_latch_r <= 16'h0000;
      else
         alarm_latch_r <= ((alarm_latch_r & ~alarm_clr) | alarm_set)
            & psa_pkg::ALARM_IMPL;
   end

   // Mask register, writable in any security state.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         alarm_mask_r <= psa_pkg::ALARM_MASK_RESET;
      else if (reg_wr && hit(reg_addr, psa_pkg::OFS_ALARM_MASK))
         alarm_mask_r <= reg_wdata & psa_pkg::ALARM_IMPL;
   end

   // Charge driver history; the reset value cannot fake a falling edge.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         charge_prev_r <= 1'b0;
      else
         charge_prev_r <= charge_driver;
   end

   // Discharge driver history; the reset value cannot fake a falling edge.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         discharge_prev_r <= 1'b0;
      else
         discharge_prev_r <= discharge_driver;
   end

   // Detector history; resets to the idle low level of the detector.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         detector_prev_r <= 1'b0;
      else
         detector_prev_r <= detector_level;
   end

   // One-shot for the initial evaluation, re-armed on leaving edit mode.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         init_seen_r <= 1'b0;
      else if (exit_edit_cmd && edit_mode_r)
         init_seen_r <= 1'b0;
      else if (init_done)
         init_seen_r <= 1'b1;
   end

   // Reset flag: set by full reset, cleared only on leaving edit mode.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         reset_flag_r <= 1'b1;
      else if (exit_edit_cmd && edit_mode_r)
         reset_flag_r <= 1'b0;
   end

   // Edit mode flag, entered only from full access.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         edit_mode_r <= 1'b0;
      else if (enter_edit_cmd && !locked)
         edit_mode_r <= 1'b1;
      else if (exit_edit_cmd)
         edit_mode_r <= 1'b0;
   end

   // Autonomous switch control: loaded on edit exit, toggled by command.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         auto_switch_r <= 1'b0;
      else if (exit_edit_cmd && edit_mode_r)
         auto_switch_r <= auto_switch_stored;
      else if (auto_switch_toggle_cmd && !locked)
         auto_switch_r <= ~auto_switch_r;
   end

   // Security state: uninitialised until first cycle, then open or locked.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         sec_r <= psa_pkg::PSA_SEC_UNINIT;
      else if (sec_r == psa_pkg::PSA_SEC_UNINIT)
         sec_r <= psa_pkg::PSA_SEC_OPEN;
      else if (seal_cmd && !locked)
         sec_r <= psa_pkg::PSA_SEC_LOCKED;
      else if (unlock_cmd && locked)
         sec_r <= psa_pkg::PSA_SEC_OPEN;
   end

   // Pack status word assembled from live state.
   always_comb
   begin
      pack_status = 16'h0000;
      pack_status[psa_pkg::PS_NORMAL] = normal_mode;
      pack_status[psa_pkg::PS_ALERT_SUMMARY] = any_set(alert_a_byte) | any_set(temp_alert);
      pack_status[psa_pkg::PS_FAULT_SUMMARY] = any_set(fault_a_byte) | any_set(temp_fault);
      pack_status[psa_pkg::PS_SEC_HI] = sec_r[1];
      pack_status[psa_pkg::PS_SEC_LO] = sec_r[0];
      pack_status[psa_pkg::PS_AUTO_SWITCH] = auto_switch_r;
      pack_status[psa_pkg::PS_RESET_FLAG] = reset_flag_r;
      pack_status[psa_pkg::PS_EDIT_MODE] = edit_mode_r;
      pack_status[psa_pkg::PS_ALERT_LINE] = alert_drv_r;
      pack_status[psa_pkg::PS_CHARGE_DRV] = charge_driver;
      pack_status[psa_pkg::PS_DISCHARGE_DRV] = discharge_driver;
      pack_status[psa_pkg::PS_DETECTOR] = detector_level;
   end

   // Read port: one cycle after the read strobe, unmapped reads return zero.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rdata_r <= '0;
      else if (reg_rd)
      begin
         if (hit(reg_addr, psa_pkg::OFS_FAULT_A))
            rdata_r <= {8'h00, fault_a_byte};
         else if (hit(reg_addr, psa_pkg::OFS_ALERT_A))
            rdata_r <= {8'h00, alert_a_byte};
         else if (hit(reg_addr, psa_pkg::OFS_TEMP_DIAG_FAULT))
            rdata_r <= {8'h00, temp_fault};
         else if (hit(reg_addr, psa_pkg::OFS_TEMP_DIAG_ALERT))
            rdata_r <= {8'h00, temp_alert};
         else if (hit(reg_addr, psa_pkg::OFS_PACK_STATUS))
            rdata_r <= pack_status;
         else if (hit(reg_addr, psa_pkg::OFS_ALARM_LATCH))
            rdata_r <= alarm_latch_r;
         else if (hit(reg_addr, psa_pkg::OFS_ALARM_LIVE))
            rdata_r <= alarm_live & psa_pkg::ALARM_IMPL;
         else if (hit(reg_addr, psa_pkg::OFS_ALARM_MASK))
            rdata_r <= alarm_mask_r;
         else
            rdata_r <= '0;
      end
   end

   // Refusal of configuration access while locked, one cycle after the try.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         refused_r <= 1'b0;
      else
         refused_r <= cfg_access & locked;
   end

   // Edit-window permission: only in edit mode and never while locked.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         cfg_allowed <= 1'b0;
      else
         cfg_allowed <= edit_mode_r & ~locked;
   end

   // Alert line: driven low while any latch bit is set, released otherwise.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         alert_drv_r <= 1'b0;
      else
         alert_drv_r <= |alarm_latch_r;
   end

   // Open-drain level register: the pin is only ever pulled low.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         alert_lvl_r <= 1'b0;
      else
         alert_lvl_r <= 1'b0;
   end

   assign reg_rdata = rdata_r;
   assign reg_refused = refused_r;
   assign auto_switch_ctrl = auto_switch_r;
   assign alert_n_oe = alert_drv_r;
   assign alert_n_out = alert_lvl_r; // Open drain: only ever pulls low.

endmodule // psa_status_alarm

/* File: psa_status_alarm_assertions.sv */
// Checker of read paths, alert line and refusals of the status and alarm logic.
module psa_status_alarm_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_rdata,
   input wire logic [7:0] fault_a_byte,
   input wire logic [7:0] temp_fault_in,
   input wire logic [7:0] temp_alert_in,
   input wire logic normal_mode,
   input wire logic cfg_access,
   input wire logic reg_refused,
   input wire logic alert_n_out,
   input wire logic alert_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Read strobes aimed at the watched registers.
   wire logic rd_tf = reg_rd && reg_addr == psa_pkg::OFS_TEMP_DIAG_FAULT;
   wire logic rd_ta = reg_rd && reg_addr == psa_pkg::OFS_TEMP_DIAG_ALERT;
   wire logic rd_ps = reg_rd && reg_addr == psa_pkg::OFS_PACK_STATUS;
   wire logic rd_lv = reg_rd && reg_addr == psa_pkg::OFS_ALARM_LIVE;
   temp_fault_a: assert property (
      rd_tf |=> reg_rdata == {8'h00, $past(temp_fault_in) & 8'hfb})
      else $error("temp fault byte read wrong");
   temp_alert_a: assert property (
      rd_ta |=> reg_rdata == {8'h00, $past(temp_alert_in) & 8'hfb})
      else $error("temp alert byte read wrong");
   normal_flag_a: assert property (
      rd_ps |=> reg_rdata[15] == $past(normal_mode))
      else $error("normal flag read wrong");
   line_flag_a: assert property (
      rd_ps |=> reg_rdata[4] == $past(alert_n_oe))
      else $error("alert line flag read wrong");
   live_fault_a: assert property (
      rd_lv |=> reg_rdata[15] == |$past(fault_a_byte))
      else $error("live fault bit read wrong");
   alert_low_a: assert property (
      alert_n_oe |-> !alert_n_out)
      else $error("alert line driven high");
   refuse_cause_a: assert property (
      reg_refused |-> $past(cfg_access))
      else $error("refusal without access");
   refuse_pulse_a: assert property (
      reg_refused && !cfg_access |=> !reg_refused)
      else $error("refusal held too long");
endmodule // psa_status_alarm_checker

bind psa_status_alarm psa_status_alarm_checker u_chk (.core_clk, .resetn, .reg_rd, .reg_addr,
   .reg_rdata, .fault_a_byte, .temp_fault_in, .temp_alert_in, .normal_mode, .cfg_access,
   .reg_refused, .alert_n_out, .alert_n_oe);

/* File: psa_host.sv */
// Host model issuing register strobes to the status and alarm logic.
module psa_host (
   input wire logic core_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Strobes rest low until the first request.
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   end
   // One-cycle write; data is scrambled afterwards so stale values never match.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // One-cycle read; the answer is taken once the sampling edge has settled.
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
endmodule // psa_host

/* File: psa_status_alarm_tb.sv */
// Self-checking testbench of the status and alarm logic.
module psa_status_alarm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] LAT = psa_pkg::OFS_ALARM_LATCH;
   localparam logic [7:0] LIV = psa_pkg::OFS_ALARM_LIVE;
   localparam logic [7:0] PST = psa_pkg::OFS_PACK_STATUS;
   localparam logic [7:0] MSK = psa_pkg::OFS_ALARM_MASK;
   logic core_clk, resetn, normal_mode, charge_driver, discharge_driver, detector_level;
   logic low_voltage_shutdown, check_tick, init_done, enter_edit_cmd, exit_edit_cmd;
   logic auto_switch_toggle_cmd, auto_switch_stored, seal_cmd, unlock_cmd, cfg_access;
   logic reg_wr, reg_rd, reg_refused, cfg_allowed, auto_switch_ctrl, alert_n_out, alert_n_oe;
   logic [7:0] fault_a_byte, alert_a_byte, temp_fault_in, temp_alert_in, reg_addr;
   logic [15:0] reg_wdata, reg_rdata, q;
   int failures, n_checks, cyc;
   // Latch bit expected from each source of the sweep.
   logic [15:0] lat_e [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
      16'h0400, 16'h0200, 16'h00c0, 16'h0004, 16'h0002};
   psa_status_alarm u_dut (.core_clk, .resetn, .fault_a_byte, .alert_a_byte, .temp_fault_in,
      .temp_alert_in, .normal_mode, .charge_driver, .discharge_driver, .detector_level,
      .low_voltage_shutdown, .check_tick, .init_done, .enter_edit_cmd, .exit_edit_cmd,
      .auto_switch_toggle_cmd, .auto_switch_stored, .seal_cmd, .unlock_cmd, .reg_wr, .reg_rd,
      .cfg_access, .reg_addr, .reg_wdata, .reg_rdata, .reg_refused, .cfg_allowed,
      .auto_switch_ctrl, .alert_n_out, .alert_n_oe);
   psa_host u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
   // Free-running 250 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Hang guard: running out of cycles counts as a mismatch.
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         give_verdict();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      u_host.rd(a, q);
      chk(q, e);
   endtask
   // Drives one alarm source of the sweep to its active or idle level.
   task automatic src(input int i, input logic v);
      @(posedge core_clk);
      case (i)
         0: fault_a_byte <= {v, 7'h00};
         1: temp_fault_in <= {6'h00, v, 1'b0};
         2: alert_a_byte <= {v, 7'h00};
         3: temp_alert_in <= {7'h00, v};
         4: charge_driver <= !v;
         5: discharge_driver <= !v;
         6: low_voltage_shutdown <= v;
         7: {normal_mode, check_tick} <= {v, v};
         8: init_done <= v;
         default: detector_level <= v;
      endcase
   endtask
   task automatic t_boot();
      repeat (3) @(posedge core_clk);
      rc(LAT, 16'h0001);
      chk(16'(alert_n_oe), 16'h0001);
      chk(16'(alert_n_out), 16'h0000);
      rc(PST, 16'h049c);
   endtask
   task automatic t_edit();
      u_host.wr(LAT, 16'h0000);
      rc(LAT, 16'h0001);
      @(posedge core_clk) enter_edit_cmd <= 1'b1;
      @(posedge core_clk) enter_edit_cmd <= 1'b0;
      repeat (4) @(posedge core_clk);
      rc(PST, 16'h04bc);
      chk(16'(cfg_allowed), 16'h0001);
      @(posedge core_clk) exit_edit_cmd <= 1'b1;
      auto_switch_stored <= 1'b1;
      @(posedge core_clk) exit_edit_cmd <= 1'b0;
      repeat (4) @(posedge core_clk);
      rc(PST, 16'h051c);
      u_host.wr(LAT, 16'hffff);
      rc(LAT, 16'h0000);
      repeat (2) @(posedge core_clk);
      chk(16'(alert_n_oe), 16'h0000);
   endtask
   task automatic t_sweep();
      for (int i = 0; i < 10; i++)
      begin
         src(i, 1'b1);
         @(posedge core_clk) check_tick <= 1'b0;
         repeat (3) @(posedge core_clk);
         rc(LAT, lat_e[i]);
         rc(LIV, i < 7 ? lat_e[i] : (i == 9 ? 16'h0002 : 16'h0000));
         if (i < 4)
            rc(PST, 16'h051c | (i < 2 ? 16'h1000 : 16'h2000));
         if (i == 9)
            rc(PST, 16'h051e);
         src(i, 1'b0);
         repeat (3) @(posedge core_clk);
         u_host.wr(LAT, 16'hffff);
         rc(LAT, 16'h0000);
      end
   endtask
   task automatic t_mask();
      u_host.wr(MSK, 16'h0000);
      src(0, 1'b1);
      temp_fault_in <= 8'hff;
      temp_alert_in <= 8'hff;
      repeat (3) @(posedge core_clk);
      rc(MSK, 16'h0000);
      rc(LAT, 16'h0000);
      rc(LIV, 16'hd000);
      rc(psa_pkg::OFS_TEMP_DIAG_FAULT, 16'h00fb);
      rc(psa_pkg::OFS_TEMP_DIAG_ALERT, 16'h00fb);
      rc(PST, 16'h350c);
      rc(8'h40, 16'h0000);
      @(posedge core_clk) {fault_a_byte, temp_fault_in, temp_alert_in} <= '0;
      u_host.wr(MSK, 16'hffff);
   endtask
   task automatic t_lock();
      @(posedge core_clk) auto_switch_toggle_cmd <= 1'b1;
      @(posedge core_clk) auto_switch_toggle_cmd <= 1'b0;
      @(posedge core_clk) seal_cmd <= 1'b1;
      @(posedge core_clk) seal_cmd <= 1'b0;
      rc(PST, 16'h0c0c);
      chk(16'(auto_switch_ctrl), 16'h0000);
      @(posedge core_clk) cfg_access <= 1'b1;
      @(posedge core_clk) cfg_access <= 1'b0;
      #1 chk(16'(reg_refused), 16'h0001);
      @(posedge core_clk) enter_edit_cmd <= 1'b1;
      #1 chk(16'(reg_refused), 16'h0000);
      @(posedge core_clk) enter_edit_cmd <= 1'b0;
      @(posedge core_clk) unlock_cmd <= 1'b1;
      @(posedge core_clk) unlock_cmd <= 1'b0;
      rc(PST, 16'h040c);
      chk(16'(cfg_allowed), 16'h0000);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Idle inputs, reset for 16 cycles, then the scenarios in turn.
   initial
   begin
      {normal_mode, detector_level, low_voltage_shutdown, check_tick, init_done} = '0;
      {enter_edit_cmd, exit_edit_cmd, auto_switch_toggle_cmd, auto_switch_stored} = '0;
      {seal_cmd, unlock_cmd, cfg_access, resetn} = '0;
      {fault_a_byte, alert_a_byte, temp_fault_in, temp_alert_in} = '0;
      {charge_driver, discharge_driver} = 2'b11;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      t_boot();
      t_edit();
      t_sweep();
      t_mask();
      t_lock();
      give_verdict();
   end
endmodule // psa_status_alarm_tb
